// ### design/uhf_pkg.sv
// Function
// - A one written to any bit of the host interrupt set register that is set in IRQ_VALID_MASK sets that bit of the host interrupt flags.
// - A zero written to any bit of the host interrupt set register leaves that interrupt flag as it was.
// - The frame-length field at bits 23 to 16 returns the upper eight bits of the fourteen-bit frame counter.
// - The frame counter runs on a 12 MHz timebase over 12000 counts, giving one start of frame per millisecond.
// - The eleven-bit start-of-frame number reads with bits 10 to 5 at bits 13 to 8 and bits 4 to 0 at bits 7 to 3.
// - Software may write the start-of-frame number and numbering continues from the written value.
package uhf_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          ADDR_W              = 12;
	localparam logic [11:0] ADDR_IRQ_FLAGS      = 12'h404;
	localparam logic [11:0] ADDR_IRQ_CLEAR      = 12'h408;
	localparam logic [11:0] ADDR_IRQ_MASK       = 12'h410;
	localparam logic [11:0] ADDR_IRQ_SET        = 12'h418;
	localparam logic [11:0] ADDR_FRAME_NUMBER   = 12'h420;
	localparam logic [11:0] ADDR_PIPE_ADDR_FIRST = 12'h424;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] IRQ_VALID_MASK      = 32'h7E00_7F7F;
	localparam int          IRQ_SOF_BIT         = 5;
	localparam logic [31:0] RESET_IRQ_FLAGS     = 32'h0000_0000;
	localparam logic [31:0] RESET_IRQ_MASK      = 32'h0000_0000;
	localparam logic [31:0] RESET_PIPE_ADDR     = 32'h0000_0000;
	localparam logic [10:0] RESET_SOF_COUNT     = 11'h000;
	localparam int          SOF_W               = 11;
	localparam int          SOF_LSB             = 3;
	localparam int          FLEN_W              = 8;
	localparam int          FLEN_LSB            = 16;
	localparam int          FRAME_CNT_W         = 14;
	localparam int          PIPE_ADDR_W         = 7;
	localparam int          PIPE_ADDR_STRIDE    = 8;
	localparam int          PIPE_ADDR_COUNT     = 4;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          SYS_CLK_KHZ         = 10000;
	localparam int          TIMEBASE_KHZ        = 12000;
	localparam int          SOF_PERIOD_US       = 1000;
	localparam int          FRAME_LEN_COUNTS    =
		TIMEBASE_KHZ * SOF_PERIOD_US / 1000;
	// one extra timebase tick is owed every this many system cycles
	localparam int          PHASE_DEN           =
		SYS_CLK_KHZ / (TIMEBASE_KHZ - SYS_CLK_KHZ);

endpackage

// ### design/uhf_frame_timer.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_frame_timer
#(
	parameter int frame_len = uhf_pkg::FRAME_LEN_COUNTS
)
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	output logic [13:0]      frame_cnt,
	output logic             expire
);

	logic [2:0]  phase;
	logic [2:0]  next_phase;
	logic [13:0] next_frame_cnt;
	logic        next_expire;
	logic [14:0] sum;

	// ------------------------------------------------------------
	// 12 MHz timebase from the 10 MHz clock
	// ------------------------------------------------------------
	// six ticks per five cycles: no second clock to cross, at the cost
	// of the counter skipping an odd value now and then
	always_comb
	begin
		sum = 15'h0000;
		if (phase == 3'(uhf_pkg::PHASE_DEN - 1))
		begin
			next_phase = 3'h0;
			sum = {1'b0, frame_cnt} + 15'h0002;
		end
		else
		begin
			next_phase = phase + 3'h1;
			sum = {1'b0, frame_cnt} + 15'h0001;
		end
		if (sum >= 15'(frame_len))
		begin
			next_frame_cnt = 14'(sum - 15'(frame_len));
			next_expire = 1'b1;
		end
		else
		begin
			next_frame_cnt = sum[13:0];
			next_expire = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			phase <= 3'h0;
			frame_cnt <= 14'h0000;
			expire <= 1'b0;
		end
		else
		begin
			phase <= next_phase;
			frame_cnt <= next_frame_cnt;
			expire <= next_expire;
		end
	end

endmodule
`default_nettype wire

// ### design/uhf_irq_flags.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_irq_flags
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [31:0] set_hw,
	input  wire logic [31:0] set_sw,
	input  wire logic [31:0] clear_sw,
	output logic [31:0]      flags
);

	logic [31:0] next_flags;

	// ------------------------------------------------------------
	// one sticky flag per bit set in IRQ_VALID_MASK, other bits held at zero; a set beats a clear in the same cycle
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 32; i++)
		begin : g_flag
			always_comb
			begin
				if (uhf_pkg::IRQ_VALID_MASK[i])
					next_flags[i] = set_hw[i] | set_sw[i] |
						(flags[i] & ~clear_sw[i]);
				else
					next_flags[i] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			flags <= uhf_pkg::RESET_IRQ_FLAGS;
		else
			flags <= next_flags;
	end

endmodule
`default_nettype wire

// ### design/uhf_host_regs.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module uhf_host_regs
#(
	parameter int frame_len = uhf_pkg::FRAME_LEN_COUNTS
)
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	input  wire logic [31:0] hw_irq_events,
	output logic             irq,
	output logic             sof_pulse,
	output logic [10:0]      sof_count,
	output logic [7:0]       frame_len_upper,
	output logic [6:0]       pipe0_target_address,
	output logic [6:0]       pipe1_target_address,
	output logic [6:0]       pipe2_target_address,
	output logic [6:0]       pipe3_target_address
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic wr_flags_clear;
	logic wr_irq_set;
	logic wr_irq_mask;
	logic wr_frame;
	logic wr_pipe_addr;

	always_comb
	begin
		wr_flags_clear = reg_wr && (reg_addr == uhf_pkg::ADDR_IRQ_CLEAR);
		wr_irq_set     = reg_wr && (reg_addr == uhf_pkg::ADDR_IRQ_SET);
		wr_irq_mask    = reg_wr && (reg_addr == uhf_pkg::ADDR_IRQ_MASK);
		wr_frame       = reg_wr &&
			(reg_addr == uhf_pkg::ADDR_FRAME_NUMBER);
		wr_pipe_addr   = reg_wr &&
			(reg_addr == uhf_pkg::ADDR_PIPE_ADDR_FIRST);
	end

	// ------------------------------------------------------------
	// frame counter
	// ------------------------------------------------------------
	logic [13:0] frame_cnt;
	logic        frame_expire;

	uhf_frame_timer
	#(
		.frame_len (frame_len)
	)
	u_timer
	(
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.frame_cnt (frame_cnt),
		.expire    (frame_expire)
	);

	// ------------------------------------------------------------
	// start-of-frame number
	// ------------------------------------------------------------
	logic [10:0] next_sof_count;
	logic        next_sof_pulse;

	// a write in the expiry cycle wins, so software sees exactly the
	// value it wrote and the next frame counts on from there
	always_comb
	begin
		next_sof_pulse = frame_expire;
		if (wr_frame)
			next_sof_count = reg_wdata[uhf_pkg::SOF_LSB +:
				uhf_pkg::SOF_W];
		else if (frame_expire)
			next_sof_count = sof_count + 11'h001;
		else
			next_sof_count = sof_count;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sof_count <= uhf_pkg::RESET_SOF_COUNT;
			sof_pulse <= 1'b0;
		end
		else
		begin
			sof_count <= next_sof_count;
			sof_pulse <= next_sof_pulse;
		end
	end

	// ------------------------------------------------------------
	// frame length view
	// ------------------------------------------------------------
	logic [7:0] next_frame_len_upper;

	always_comb
	begin
		next_frame_len_upper = frame_cnt[13:6];
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			frame_len_upper <= 8'h00;
		else
			frame_len_upper <= next_frame_len_upper;
	end

	// ------------------------------------------------------------
	// pipe target addresses
	// ------------------------------------------------------------
	logic [31:0] pipe_addr;
	logic [31:0] next_pipe_addr;
	logic [31:0] pipe_addr_mask;

	genvar p;
	generate
		for (p = 0; p < uhf_pkg::PIPE_ADDR_COUNT; p++)
		begin : g_pipe_mask
			assign pipe_addr_mask[p * uhf_pkg::PIPE_ADDR_STRIDE +:
				uhf_pkg::PIPE_ADDR_STRIDE] =
				{1'b0, {uhf_pkg::PIPE_ADDR_W{1'b1}}};
		end
	endgenerate

	always_comb
	begin
		if (wr_pipe_addr)
			next_pipe_addr = reg_wdata & pipe_addr_mask;
		else
			next_pipe_addr = pipe_addr;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			pipe_addr <= uhf_pkg::RESET_PIPE_ADDR;
		else
			pipe_addr <= next_pipe_addr;
	end

	always_comb
	begin
		pipe0_target_address = pipe_addr[6:0];
		pipe1_target_address = pipe_addr[14:8];
		pipe2_target_address = pipe_addr[22:16];
		pipe3_target_address = pipe_addr[30:24];
	end

	// ------------------------------------------------------------
	// interrupt flags and mask
	// ------------------------------------------------------------
	logic [31:0] irq_flags;
	logic [31:0] irq_mask;
	logic [31:0] next_irq_mask;
	logic [31:0] set_hw;
	logic [31:0] set_sw;
	logic [31:0] clear_sw;
	logic        next_irq;

	always_comb
	begin
		set_hw = hw_irq_events;
		set_hw[uhf_pkg::IRQ_SOF_BIT] = hw_irq_events[uhf_pkg::IRQ_SOF_BIT]
			| frame_expire;
		// zeros in the written word contribute nothing
		set_sw   = wr_irq_set ? reg_wdata : 32'h0000_0000;
		clear_sw = wr_flags_clear ? reg_wdata : 32'h0000_0000;
	end

	uhf_irq_flags u_flags
	(
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.set_hw   (set_hw),
		.set_sw   (set_sw),
		.clear_sw (clear_sw),
		.flags    (irq_flags)
	);

	always_comb
	begin
		if (wr_irq_mask)
			next_irq_mask = reg_wdata & uhf_pkg::IRQ_VALID_MASK;
		else
			next_irq_mask = irq_mask;
		next_irq = |(irq_flags & irq_mask);
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_mask <= uhf_pkg::RESET_IRQ_MASK;
			irq <= 1'b0;
		end
		else
		begin
			irq_mask <= next_irq_mask;
			irq <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [31:0] next_rdata;

	// data stands one cycle only; the set and clear registers read zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			case (reg_addr)
				uhf_pkg::ADDR_IRQ_FLAGS:
					next_rdata = irq_flags;
				uhf_pkg::ADDR_IRQ_MASK:
					next_rdata = irq_mask;
				uhf_pkg::ADDR_FRAME_NUMBER:
				begin
					next_rdata[uhf_pkg::FLEN_LSB +: uhf_pkg::FLEN_W] =
						frame_cnt[13:6];
					next_rdata[uhf_pkg::SOF_LSB +: uhf_pkg::SOF_W] =
						sof_count;
				end
				uhf_pkg::ADDR_PIPE_ADDR_FIRST:
					next_rdata = pipe_addr;
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= next_rdata;
	end

endmodule
`default_nettype wire

// ### verif/uhf_host_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_host_regs_checker
#(
	parameter int frame_len = uhf_pkg::FRAME_LEN_COUNTS
)
(
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        irq,
	input  wire logic        sof_pulse,
	input  wire logic [10:0] sof_count,
	input  wire logic [7:0]  frame_len_upper
);
	logic [31:0] mask_q;
	logic [31:0] next_mask_q;
	logic        fwr;
	logic [10:0] wr_sof;
	logic [15:0] gap;
	logic [15:0] next_gap;
	// six timebase ticks per five system cycles
	localparam int SOF_GAP = frame_len * 5 / 6;
	assign fwr = reg_wr && reg_addr == uhf_pkg::ADDR_FRAME_NUMBER;
	assign wr_sof = reg_wdata[13:3];
	// cycles since the last frame pulse; zero until the first one
	always_comb
	begin
		next_gap = gap;
		if (sof_pulse)
			next_gap = 16'h0001;
		else if (gap != 16'h0000 && gap != 16'hFFFF)
			next_gap = gap + 16'h0001;
	end
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			gap <= 16'h0000;
		else
			gap <= next_gap;
	// shadow of the mask so irq can be tied to its cause
	always_comb
	begin
		next_mask_q = mask_q;
		if (reg_wr && reg_addr == uhf_pkg::ADDR_IRQ_MASK)
			next_mask_q = reg_wdata & uhf_pkg::IRQ_VALID_MASK;
	end
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
			mask_q <= 32'h0000_0000;
		else
			mask_q <= next_mask_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	AST_IRQ_SET: assert property (
		reg_wr && reg_addr == uhf_pkg::ADDR_IRQ_SET
		&& |(reg_wdata & mask_q) |-> ##2 irq)
		else $error("irq missing after set write");
	AST_IRQ_KEEP: assert property (
		irq && !$past(reg_wr) && reg_wr
		&& reg_addr == uhf_pkg::ADDR_IRQ_SET && reg_wdata == 0 |=> irq)
		else $error("zero set write dropped irq");
	AST_FLEN_RANGE: assert property (
		frame_len_upper <= (frame_len - 1) / 64)
		else $error("frame length field out of range");
	AST_RD_FLEN: assert property (
		reg_rd && reg_addr == uhf_pkg::ADDR_FRAME_NUMBER
		|=> reg_rdata[23:16] == frame_len_upper)
		else $error("frame length read differs from counter");
	AST_SOF_PERIOD: assert property (
		sof_pulse && gap != 16'h0000 |-> gap == 16'(SOF_GAP))
		else $error("frame period wrong");
	AST_SOF_DUE: assert property (
		gap <= 16'(SOF_GAP))
		else $error("frame expiry overdue");
	AST_RD_FRAME: assert property (
		reg_rd && reg_addr == uhf_pkg::ADDR_FRAME_NUMBER
		|=> sof_pulse || (reg_rdata[13:3] == sof_count && reg_rdata[2:0] == 0
		&& reg_rdata[15:14] == 0 && reg_rdata[31:24] == 0))
		else $error("frame number read layout wrong");
	AST_SOF_WRITE: assert property (
		fwr |=> sof_count == $past(wr_sof))
		else $error("frame number write lost");
	AST_SOF_STEP: assert property (
		sof_pulse && !$past(fwr)
		|-> sof_count == $past(sof_count) + 11'h1)
		else $error("frame number did not step");
	AST_SOF_HOLD: assert property (
		!sof_pulse && !$past(fwr) |-> $stable(sof_count))
		else $error("frame number moved without expiry");
endmodule
bind uhf_host_regs uhf_host_regs_checker #(.frame_len(frame_len)) i_chk (
	.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .irq(irq), .sof_pulse(sof_pulse),
	.sof_count(sof_count), .frame_len_upper(frame_len_upper));
`default_nettype wire

// ### verif/uhf_event_source.sv
`timescale 1ns/100ps
`default_nettype none
module uhf_event_source
(
	input  wire logic        sys_clk,
	input  wire logic        fire,
	input  wire logic [31:0] bits,
	output logic [31:0]      hw_irq_events
);
	// one-cycle bursts, quiet in between
	always @(posedge sys_clk)
		hw_irq_events <= fire ? bits : 32'h0000_0000;
endmodule
`default_nettype wire

// ### verif/uhf_host_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module uhf_host_regs_tb;
	localparam logic [31:0] VM = uhf_pkg::IRQ_VALID_MASK;
	localparam logic [11:0] RA [7] = '{12'h404, 12'h408, 12'h410, 12'h418,
		12'h420, 12'h424, 12'h7FC};
	logic        sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        fire = 1'b0, irq, sof_pulse;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000, bits = 32'h0000_0000;
	logic [31:0] reg_rdata, hw_irq_events, d, p, fl_m;
	logic [10:0] sof_count, sv;
	logic [7:0]  frame_len_upper;
	logic [6:0]  pa0, pa1, pa2, pa3;
	int          comparisons = 0, miscompares = 0, seed = 64, n;
	uhf_host_regs #(.frame_len(120)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_irq_events(hw_irq_events),
		.irq(irq), .sof_pulse(sof_pulse), .sof_count(sof_count),
		.frame_len_upper(frame_len_upper), .pipe0_target_address(pa0),
		.pipe1_target_address(pa1), .pipe2_target_address(pa2),
		.pipe3_target_address(pa3));
	uhf_event_source i_src (.sys_clk(sys_clk), .fire(fire), .bits(bits),
		.hw_irq_events(hw_irq_events));
	initial forever #50 sys_clk = ~sys_clk;
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic end_of_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wait_sof;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1 n++;
		end while (!sof_pulse && n < 300);
		if (n >= 300)
		begin
			miscompares++;
			end_of_test;
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		end_of_test;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (RA[i])
		begin
			rd(RA[i]);
			`CHK(d, 32'h0000_0000)
		end
		fl_m = 32'h0000_0000;
		// bit 5 also follows frame expiry, so it is left out here
		repeat (6)
		begin
			@(posedge sys_clk);
			bits <= $random(seed);
			fire <= 1'b1;
			@(posedge sys_clk);
			fire <= 1'b0;
			fl_m = fl_m | (bits & VM);
			p = $random(seed);
			wr(uhf_pkg::ADDR_IRQ_SET, p);
			fl_m = fl_m | (p & VM);
			wr(uhf_pkg::ADDR_IRQ_SET, 32'h0000_0000);
			rd(uhf_pkg::ADDR_IRQ_FLAGS);
			`CHK(d & ~32'h20, fl_m & ~32'h20)
			p = $random(seed);
			wr(uhf_pkg::ADDR_IRQ_CLEAR, p);
			fl_m = fl_m & ~p;
		end
		wr(uhf_pkg::ADDR_IRQ_CLEAR, 32'hFFFF_FFFF);
		wr(uhf_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		wr(uhf_pkg::ADDR_IRQ_SET, 32'h0000_0001);
		@(posedge sys_clk);
		#1 `CHK(irq, 1'b1)
		wr(uhf_pkg::ADDR_IRQ_SET, 32'h0000_0000);
		@(posedge sys_clk);
		#1 `CHK(irq, 1'b1)
		wr(uhf_pkg::ADDR_IRQ_CLEAR, 32'h0000_0001);
		@(posedge sys_clk);
		#1 `CHK(irq, 1'b0)
		for (int k = 0; k < 2; k++)
		begin
			sv = k ? 11'($random(seed)) : 11'h7FF;
			wait_sof;
			wr(uhf_pkg::ADDR_FRAME_NUMBER, {18'h0, sv, 3'h0});
			rd(uhf_pkg::ADDR_FRAME_NUMBER);
			`CHK(d[13:3], sv)
			wait_sof;
			`CHK(n inside {[95:97]}, 1'b1)
			`CHK(sof_count, sv + 11'h1)
			rd(uhf_pkg::ADDR_FRAME_NUMBER);
			`CHK(d & 32'hFF00_FFFF, {16'h0, 2'b0, sv + 11'h1, 3'b0})
			`CHK(d[23:16], 8'h00)
			`CHK(frame_len_upper, 8'h00)
			// some 64 cycles into the frame the counter sits near 77
			repeat (60) @(posedge sys_clk);
			rd(uhf_pkg::ADDR_FRAME_NUMBER);
			`CHK(d[23:16], 8'h01)
			`CHK(frame_len_upper, 8'h01)
		end
		p = $random(seed);
		wr(uhf_pkg::ADDR_PIPE_ADDR_FIRST, p);
		rd(uhf_pkg::ADDR_PIPE_ADDR_FIRST);
		`CHK(d, p & 32'h7F7F_7F7F)
		`CHK({pa3, pa2, pa1, pa0}, {p[30:24], p[22:16], p[14:8], p[6:0]})
		end_of_test;
	end
endmodule
`default_nettype wire
